// ==== design/supply_monitor_map.vh ====
`ifndef SUPPLY_MONITOR_MAP_VH
`define SUPPLY_MONITOR_MAP_VH

// Register byte offsets on the APB slave.
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_THRESH      12'h008
`define OFS_RESULT      12'h00C
`define OFS_INT_STAT    12'h010
`define OFS_INT_MASK    12'h014
`define OFS_DEB_LIMIT   12'h018
`define OFS_TICK        12'h01C

// Control register fields.
`define CTRL_ENABLE     0
`define CTRL_LAMP_OPT   1

// Interrupt status fields.
`define IRQ_WAKE        0
`define IRQ_FINISH      1
`define IRQ_STEP        2
`define IRQ_W           3

// Threshold table.
`define TH_0            16'h0DED
`define TH_1            16'h0BD6
`define TH_2            16'h0978
`define TH_3            16'h07E4
`define TH_4            16'h06C3
`define TH_5            16'h05EB
`define TH_6            16'h0542
`define TH_7            16'h04BC
`define TH_LAST_IDX     3'h7

// Converter sequence and debounce constants.
`define LOOP_INIT       2'h2
`define SETTLE_CYCLES   8'h60
`define DEB_LIMIT_RST   16'h0014
`define CHAN_INIT       5'h00
`define CHAN_VREF       5'h1F

`endif

// ==== design/supply_monitor.v ====
// Overview of operation
// - On a start trigger the sequencer steps through its instruction slots in ascending order, going back from store to convert for the second conversion.
// - Working values such as threshold, result and loop count are held in the sequencer general registers.
// - An interval timer interrupt starts a run that configures the converter and converts.
// - With the internal reference selected two conversions are made and only the second result kept.
// - After converting, the converter is stopped and its channel restored before the decision.
// - A result at or above the threshold ends the run with a CPU wake-up request.
// - A result below the threshold ends the run without wake-up so the system returns to stop.
// - The threshold starts at 0DED and each button press steps it through the table down to 04BC.
// - With the lamp option on, every completed run toggles the status lamp.
// - A button press raises the external pin interrupt whose handling waits out a debounce before acting.
// - The debounce wait polls the millisecond tick count and ends only when it exceeds the debounce limit.
// - Each timer channel 7 interrupt adds one to the millisecond tick count, except in the cycle a debounce starts and clears it.
// - Each run loads the conversion loop counter with 2 and decrements it per conversion to zero.
`include "supply_monitor_map.vh"

module supply_monitor (
	// APB slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Triggers from pins and timers
	input  wire        interval_timer_32,
	input  wire        timer_ch7_interrupt,
	input  wire        user_button,
	// Converter handshake
	output reg         adc_enable,
	output reg         adc_start,
	output reg  [4:0]  adc_channel,
	input  wire        adc_done,
	input  wire [15:0] adc_result,
	// Outcomes
	output reg         cpu_wake,
	output reg         status_lamp,
	output reg         irq
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detection.

reg [1:0] itmr_s_r;
reg [1:0] tick_s_r;
reg [1:0] btn_s_r;
reg [1:0] done_s_r;
reg       itmr_d_r;
reg       tick_d_r;
reg       btn_d_r;
reg       done_d_r;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		itmr_s_r <= 2'h0;
		tick_s_r <= 2'h0;
		btn_s_r  <= 2'h0;
		done_s_r <= 2'h0;
		itmr_d_r <= 1'b0;
		tick_d_r <= 1'b0;
		btn_d_r  <= 1'b0;
		done_d_r <= 1'b0;
	end else begin
		itmr_s_r <= {itmr_s_r[0], interval_timer_32};
		tick_s_r <= {tick_s_r[0], timer_ch7_interrupt};
		btn_s_r  <= {btn_s_r[0], user_button};
		done_s_r <= {done_s_r[0], adc_done};
		itmr_d_r <= itmr_s_r[1];
		tick_d_r <= tick_s_r[1];
		btn_d_r  <= btn_s_r[1];
		done_d_r <= done_s_r[1];
	end
end

wire itmr_rise = itmr_s_r[1] & ~itmr_d_r;
wire tick_rise = tick_s_r[1] & ~tick_d_r;
wire btn_rise  = btn_s_r[1] & ~btn_d_r;
wire done_rise = done_s_r[1] & ~done_d_r;

////////////////////////////////////////////////////////////////////////
// Registers.

localparam IRQ_TOP = `IRQ_W - 1;
reg  [1:0]  ctrl_r;
reg  [15:0] deb_limit_r;
reg  [15:0] tick_cnt_r;
reg  [2:0]  th_idx_r;
reg  [IRQ_TOP:0] int_stat_r;
reg  [IRQ_TOP:0] int_mask_r;

// Sequencer general registers: 0 threshold, 1 result, 2 loop count.
reg  [15:0] gen_r [0:15];
reg  [15:0] threshold;

always @* begin
	case (th_idx_r)
		3'h0:    threshold = `TH_0;
		3'h1:    threshold = `TH_1;
		3'h2:    threshold = `TH_2;
		3'h3:    threshold = `TH_3;
		3'h4:    threshold = `TH_4;
		3'h5:    threshold = `TH_5;
		3'h6:    threshold = `TH_6;
		default: threshold = `TH_7;
	endcase
end

////////////////////////////////////////////////////////////////////////
// Sequencer.

localparam S_IDLE   = 4'h0;
localparam S_LOAD   = 4'h1;
localparam S_CFG    = 4'h2;
localparam S_SETTLE = 4'h3;
localparam S_CONV   = 4'h4;
localparam S_WAIT   = 4'h5;
localparam S_STORE  = 4'h6;
localparam S_STOP   = 4'h7;
localparam S_CMP    = 4'h8;
localparam S_FIN    = 4'h9;

reg [3:0] slot_r;
reg [7:0] settle_r;
reg       wake_ev;
reg       fin_ev;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		slot_r      <= S_IDLE;
		settle_r    <= 8'h00;
		adc_enable  <= 1'b0;
		adc_start   <= 1'b0;
		adc_channel <= `CHAN_INIT;
		cpu_wake    <= 1'b0;
		status_lamp <= 1'b0;
		wake_ev     <= 1'b0;
		fin_ev      <= 1'b0;
		gen_r[0]    <= 16'h0000;
		gen_r[1]    <= 16'h0000;
		gen_r[2]    <= 16'h0000;
	end else begin
		adc_start <= 1'b0;
		cpu_wake  <= 1'b0;
		wake_ev   <= 1'b0;
		fin_ev    <= 1'b0;
		case (slot_r)
			S_IDLE: begin
				if (itmr_rise && ctrl_r[`CTRL_ENABLE])
					slot_r <= S_LOAD;
			end
			S_LOAD: begin
				gen_r[2] <= {14'h0000, `LOOP_INIT};
				gen_r[0] <= threshold;
				slot_r   <= S_CFG;
			end
			S_CFG: begin
				adc_channel <= `CHAN_VREF;
				adc_enable  <= 1'b1;
				settle_r    <= `SETTLE_CYCLES;
				slot_r      <= S_SETTLE;
			end
			S_SETTLE: begin
				settle_r <= settle_r - 8'h01;
				if (settle_r == 8'h00)
					slot_r <= S_CONV;
			end
			S_CONV: begin
				adc_start <= 1'b1;
				slot_r    <= S_WAIT;
			end
			S_WAIT: begin
				if (done_rise)
					slot_r <= S_STORE;
			end
			S_STORE: begin
				// Only the last pass survives, the first reference reading is overwritten.
				gen_r[1] <= adc_result;
				gen_r[2] <= gen_r[2] - 16'h0001;
				slot_r   <= (gen_r[2] == 16'h0001) ? S_STOP : S_CONV;
			end
			S_STOP: begin
				adc_enable  <= 1'b0;
				adc_channel <= `CHAN_INIT;
				slot_r      <= S_CMP;
			end
			S_CMP: begin
				if (gen_r[1] >= gen_r[0]) begin
					cpu_wake <= 1'b1;
					wake_ev  <= 1'b1;
				end
				slot_r <= S_FIN;
			end
			S_FIN: begin
				if (ctrl_r[`CTRL_LAMP_OPT])
					status_lamp <= ~status_lamp;
				fin_ev <= 1'b1;
				slot_r <= S_IDLE;
			end
			default: slot_r <= S_IDLE;
		endcase
	end
end

genvar gi;
generate
	for (gi = 3; gi < 16; gi = gi + 1) begin : g_unused
		always @(posedge pclk or negedge presetn) begin
			if (!presetn)
				gen_r[gi] <= 16'h0000;
			else
				gen_r[gi] <= gen_r[gi];
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// Button debounce and threshold stepping.

reg deb_busy_r;
reg step_ev;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		deb_busy_r <= 1'b0;
		tick_cnt_r <= 16'h0000;
		th_idx_r   <= 3'h0;
		step_ev    <= 1'b0;
	end else begin
		step_ev <= 1'b0;
		if (btn_rise && !deb_busy_r) begin
			deb_busy_r <= 1'b1;
			tick_cnt_r <= 16'h0000;
		end else begin
			if (tick_rise)
				tick_cnt_r <= tick_cnt_r + 16'h0001;
			if (deb_busy_r && tick_cnt_r > deb_limit_r) begin
				deb_busy_r <= 1'b0;
				step_ev    <= 1'b1;
				// The table stops at the highest supply level rather than wrapping.
				if (th_idx_r != `TH_LAST_IDX)
					th_idx_r <= th_idx_r + 3'h1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// APB slave and interrupt.

wire acc    = psel & penable;
wire wr_acc = acc & pwrite;
wire rd_acc = acc & ~pwrite;
wire [IRQ_TOP:0] ev_vec = {step_ev, fin_ev, wake_ev};

reg        mapped;
reg [31:0] rd_mux;

always @* begin
	mapped = 1'b1;
	rd_mux = 32'h00000000;
	case (paddr)
		`OFS_CTRL:      rd_mux = {30'h0, ctrl_r};
		`OFS_STATUS:    rd_mux = {26'h0, deb_busy_r, th_idx_r, (slot_r != S_IDLE), status_lamp};
		`OFS_THRESH:    rd_mux = {16'h0, threshold};
		`OFS_RESULT:    rd_mux = {16'h0, gen_r[1]};
		`OFS_INT_STAT:  rd_mux = {29'h0, int_stat_r};
		`OFS_INT_MASK:  rd_mux = {29'h0, int_mask_r};
		`OFS_DEB_LIMIT: rd_mux = {16'h0, deb_limit_r};
		`OFS_TICK:      rd_mux = {16'h0, tick_cnt_r};
		default:        mapped = 1'b0;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl_r      <= 2'h0;
		deb_limit_r <= `DEB_LIMIT_RST;
		int_stat_r  <= 3'h0;
		int_mask_r  <= 3'h0;
		prdata      <= 32'h00000000;
		pready      <= 1'b0;
		pslverr     <= 1'b0;
		irq         <= 1'b0;
	end else begin
		// One wait state: answer registered, so pready rises one cycle into the access phase.
		pready  <= acc & ~pready;
		pslverr <= acc & ~pready & ~mapped;
		if (rd_acc && !pready)
			prdata <= rd_mux;
		if (wr_acc && pready && paddr == `OFS_CTRL)
			ctrl_r <= pwdata[1:0];
		if (wr_acc && pready && paddr == `OFS_INT_MASK)
			int_mask_r <= pwdata[IRQ_TOP:0];
		if (wr_acc && pready && paddr == `OFS_DEB_LIMIT)
			deb_limit_r <= pwdata[15:0];
		// A new event beats a write-one clear in the same cycle.
		if (wr_acc && pready && paddr == `OFS_INT_STAT)
			int_stat_r <= (int_stat_r & ~pwdata[IRQ_TOP:0]) | ev_vec;
		else
			int_stat_r <= int_stat_r | ev_vec;
		irq <= |(int_stat_r & int_mask_r);
	end
end

endmodule

// ==== dv/monitor_chk.sv ====
`include "supply_monitor_map.vh"
module monitor_chk (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// Register bus
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        pslverr,
	// Converter and outcomes
	input wire        adc_enable,
	input wire        adc_start,
	input wire [4:0]  adc_channel,
	input wire        cpu_wake,
	input wire        status_lamp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Counts conversion starts within one enable window.
	logic [2:0] starts_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			starts_r <= 3'h0;
		else if (!adc_enable)
			starts_r <= 3'h0;
		else
			starts_r <= starts_r + {2'h0, adc_start};
	end
	AST_PREADY: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle into the access phase");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	AST_ERR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_SETTLE: assert property ($rose(adc_enable) |-> ##[95:99] adc_start)
		else $error("first start not after the settle time");
	AST_START_REF: assert property (adc_start |-> adc_enable && adc_channel == `CHAN_VREF)
		else $error("start without reference channel enabled");
	AST_START_PULSE: assert property (adc_start |=> !adc_start)
		else $error("start pulse too long");
	AST_LOOP: assert property (adc_start |-> starts_r < 3'h2)
		else $error("more than two conversions in one run");
	AST_STOP: assert property ($fell(adc_enable) |-> starts_r == 3'h2 && adc_channel == `CHAN_INIT)
		else $error("stop without two conversions or channel restore");
	AST_WAKE: assert property (cpu_wake |-> !$past(adc_enable) && $past(adc_enable, 2))
		else $error("wake not right after converter stop");
	AST_LAMP: assert property ($changed(status_lamp) |-> $past(adc_enable, 3) && !$past(adc_enable, 2))
		else $error("lamp changed outside run end");
	COV_WAKE: cover property (cpu_wake);
	COV_LAMP: cover property ($rose(status_lamp));
	COV_ERR: cover property (pslverr);
endmodule
bind supply_monitor monitor_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .adc_enable(adc_enable), .adc_start(adc_start),
	.adc_channel(adc_channel), .cpu_wake(cpu_wake), .status_lamp(status_lamp));

// ==== dv/adc_model.sv ====
module adc_model (
	// Clock, control from the monitor, latency and value from the testbench
	input wire         pclk,
	input wire         adc_enable,
	input wire         adc_start,
	input wire  [7:0]  lat,
	input wire  [15:0] value,
	// Conversion outcome
	output logic        adc_done,
	output logic [15:0] adc_result
);
	timeunit 1ns;
	timeprecision 1ns;
	logic second;
	initial begin
		adc_done = 1'b0;
		adc_result = 16'hA5A5;
		second = 1'b0;
		forever begin
			@(negedge pclk);
			if (!adc_enable)
				second = 1'b0;
			if (adc_start) begin
				repeat (lat) @(posedge pclk);
				// The first reference sample is unsettled, so it never equals the real level.
				adc_result <= second ? value : ~value;
				adc_done <= 1'b1;
				repeat (4) @(posedge pclk);
				adc_done <= 1'b0;
				adc_result <= ~adc_result;
				second = 1'b1;
			end
		end
	end
endmodule

// ==== dv/testbench.sv ====
`include "supply_monitor_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
`define PULSE(s) begin s <= 1'b1; repeat (4) @(posedge pclk); s <= 1'b0; repeat (4) @(posedge pclk); end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, trig, tick, btn;
	logic        adc_enable, adc_start, adc_done, cpu_wake, lamp, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0]  chan;
	logic [15:0] ares, aval;
	logic [7:0]  lat;
	int          err_count, tests_run, wakes;
	supply_monitor dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.interval_timer_32(trig), .timer_ch7_interrupt(tick), .user_button(btn), .adc_enable(adc_enable),
		.adc_start(adc_start), .adc_channel(chan), .adc_done(adc_done), .adc_result(ares),
		.cpu_wake(cpu_wake), .status_lamp(lamp), .irq(irq));
	adc_model adc_u (.pclk(pclk), .adc_enable(adc_enable), .adc_start(adc_start), .lat(lat), .value(aval),
		.adc_done(adc_done), .adc_result(ares));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) if (cpu_wake === 1'b1) wakes <= wakes + 1;
	task automatic end_sim();
		$display("tests_run %0d err_count %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			end_sim();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		apb(0, `OFS_DEB_LIMIT, 0, q, e);
		`CHK(q, {16'h0, `DEB_LIMIT_RST})
		apb(0, `OFS_THRESH, 0, q, e);
		`CHK(q, {16'h0, `TH_0})
		apb(1, 12'h020, 32'hFFFF, q, e);
		`CHK(e, 1'b1)
		apb(1, `OFS_CTRL, 32'h3, q, e);
		apb(1, `OFS_INT_MASK, 32'h7, q, e);
		$display("test regs done");
	endtask
	task automatic t_run(input logic [15:0] v, input logic w_exp, input logic [7:0] l_in);
		int n, w;
		logic l, e;
		logic [31:0] q;
		aval <= v;
		lat <= l_in;
		l = lamp;
		w = wakes;
		`PULSE(trig)
		n = 0;
		while (lamp === l && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		`CHK(n < 3000, 1'b1)
		if (n >= 3000)
			end_sim();
		`CHK(wakes - w, w_exp ? 1 : 0)
		apb(0, `OFS_RESULT, 0, q, e);
		`CHK(q[15:0], v)
		apb(0, `OFS_INT_STAT, 0, q, e);
		`CHK(q[2:0], {2'b01, w_exp})
		`CHK(irq, 1'b1)
		apb(1, `OFS_INT_MASK, 32'h0, q, e);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1, `OFS_INT_MASK, 32'h7, q, e);
		apb(1, `OFS_INT_STAT, 32'h7, q, e);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b0)
		$display("test run done");
	endtask
	task automatic t_button();
		logic [15:0] tbl [8] = '{`TH_0, `TH_1, `TH_2, `TH_3, `TH_4, `TH_5, `TH_6, `TH_7};
		logic [31:0] q;
		logic e;
		apb(1, `OFS_DEB_LIMIT, 32'h2, q, e);
		for (int i = 1; i < 9; i++) begin
			`PULSE(btn)
			apb(0, `OFS_STATUS, 0, q, e);
			`CHK(q[5], 1'b1)
			`PULSE(tick)
			`PULSE(tick)
			apb(0, `OFS_THRESH, 0, q, e);
			`CHK(q[15:0], tbl[i - 1])
			`PULSE(tick)
			apb(0, `OFS_TICK, 0, q, e);
			`CHK(q[15:0], 16'h3)
			apb(0, `OFS_THRESH, 0, q, e);
			`CHK(q[15:0], tbl[i > 7 ? 7 : i])
		end
		$display("test button done");
	endtask
	initial begin
		{presetn, psel, penable, pwrite, trig, tick, btn, paddr, pwdata} = '0;
		{err_count, tests_run, wakes} = '0;
		aval = 16'h0;
		lat = 8'h2;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_run(`TH_0, 1'b1, 8'h2);
		t_run(`TH_0 - 16'h1, 1'b0, 8'h28);
		t_run(16'h8000, 1'b1, 8'h1);
		t_button();
		end_sim();
	end
endmodule
